// ---- hdl/ibg_consts.svh ----
// Register offsets, field positions, reset values and gain constants
`ifndef IBG_CONSTS_SVH
`define IBG_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define IBG_ADDR_DATA_FIRST 8'h02
`define IBG_ADDR_DATA_LAST 8'h09
`define IBG_ADDR_TRACK3 8'h2B
`define IBG_ADDR_MAKER_LO 8'hFC
`define IBG_ADDR_MAKER_HI 8'hFD
`define IBG_ADDR_PART_LO 8'hFE
`define IBG_ADDR_PART_HI 8'hFF

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define IBG_TRACK3_LSB 0
`define IBG_TRACK3_MSB 1
`define IBG_RSV_LSB 2
`define IBG_RSV_MSB 7
`define IBG_TRACK3_RST 8'h01
`define IBG_RDATA_RST 8'h00
`define IBG_UNMAPPED_DATA 8'h00

// ----------------------------------------------------------------
// Gain factor format: unsigned, 4 fraction bits
// ----------------------------------------------------------------
`define IBG_GAIN_FRAC 4
`define IBG_GAIN_RST 12'h010
`define IBG_GAIN_MAX 12'hE80

`endif

// ---- hdl/ibg_pkg.sv ----
// Types shared by the inductive button identity and gain block
package ibg_pkg;
	typedef logic [7:0] ibg_byte_type;
	typedef logic [7:0] ibg_addr_type;
	typedef logic [15:0] ibg_data_type;
	typedef logic [5:0] ibg_code_type;
	typedef logic [11:0] ibg_gain_type;
	typedef logic [1:0] ibg_ftf_type;
	typedef ibg_data_type ibg_data_arr_type [4];
	typedef ibg_code_type ibg_code_arr_type [4];
	typedef ibg_gain_type ibg_gain_arr_type [4];
endpackage

// ---- hdl/ibg_gain_if.sv ----
// Gain code and decoded factor carried between top and decoder
`timescale 1ns/10ps
interface ibg_gain_if;
	import ibg_pkg::*;
	ibg_code_type code;
	ibg_gain_type factor;
	modport dec (input code, output factor);
	modport user (output code, input factor);
endinterface

// ---- hdl/ibg_gain_dec.sv ----
// Gain code to normalized gain factor decoder
`timescale 1ns/10ps
`include "ibg_consts.svh"
module ibg_gain_dec (
	// Code in, factor out
	ibg_gain_if.dec bus
);
	import ibg_pkg::*;

	logic [4:0] mant;
	logic [2:0] expo;

	// ------------------------------------------------------------
	// Mantissa table times a power of two
	// ------------------------------------------------------------
	always_comb begin
		expo = bus.code[5:3];
		unique case (bus.code[2:0])
			3'h0: mant = 5'h10; // 1.0
			3'h1: mant = 5'h11; // 1.0625
			3'h2: mant = 5'h13; // 1.1875
			3'h3: mant = 5'h15; // 1.3125
			3'h4: mant = 5'h17; // 1.4375
			3'h5: mant = 5'h19; // 1.5625
			3'h6: mant = 5'h1B; // 1.6875
			3'h7: mant = 5'h1D; // 1.8125
		endcase
		bus.factor = ibg_gain_type'({7'h00, mant} << expo);
	end
endmodule

// ---- hdl/ibg_regs.sv ----
// Channel-3 tracking, identity codes, data window and gain decode
//
// Contract
// - Channel-3 fast tracking factor, bits 1:0, reset 01
// - Read-only maker identity at FC and FD
// - Read-only part identity, low byte per variant
// - Gain code 0..63 maps to normalized factor
// - Channel output values readable at 02..09
`timescale 1ns/10ps
`include "ibg_consts.svh"
module ibg_regs #(
	parameter logic [15:0] MAKER_IDENTITY = 16'h5A3C, // arbitrary value
	parameter logic [7:0] PART_IDENTITY_HI = 8'h6E, // arbitrary value
	parameter logic [7:0] PART_LO_TWO_CH = 8'h12, // arbitrary value
	parameter logic [7:0] PART_LO_FOUR_CH = 8'h13, // arbitrary value
	parameter bit FOUR_CHANNEL = 1'b1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register port
	input wire ibg_pkg::ibg_addr_type reg_addr,
	input wire logic reg_wr,
	input wire ibg_pkg::ibg_byte_type reg_wdata,
	input wire logic reg_rd,
	output ibg_pkg::ibg_byte_type reg_rdata,
	output logic reg_rvalid,
	// Processing core side
	input wire ibg_pkg::ibg_data_arr_type channel_output_value,
	input wire ibg_pkg::ibg_code_arr_type channel_gain_code,
	output ibg_pkg::ibg_gain_arr_type channel_gain_factor,
	output ibg_pkg::ibg_ftf_type ch3_fast_tracking_factor
);
	import ibg_pkg::*;

	ibg_byte_type track3_q, track3_d;
	ibg_byte_type rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	ibg_gain_arr_type gain_q, gain_d;
	ibg_gain_arr_type gain_dec;
	ibg_byte_type part_lo;
	ibg_gain_if gif[4] ();

	assign part_lo = FOUR_CHANNEL ? PART_LO_FOUR_CH : PART_LO_TWO_CH;

	// ------------------------------------------------------------
	// Gain decoders, one per channel
	// ------------------------------------------------------------
	for (genvar i = 0; i < 4; i++) begin : g_gain
		assign gif[i].code = channel_gain_code[i];
		assign gain_dec[i] = gif[i].factor;
		ibg_gain_dec u_dec (
			.bus(gif[i].dec)
		);
	end

	// ------------------------------------------------------------
	// Register write, read mux and gain capture
	// ------------------------------------------------------------
	always_comb begin
		ibg_addr_type off;
		off = 8'h00;
		track3_d = track3_q;
		rvalid_d = reg_rd;
		rdata_d = rdata_q;
		gain_d = gain_dec;
		// Whole byte is stored; reserved bits read back as written
		if (reg_wr && reg_addr == `IBG_ADDR_TRACK3) begin
			track3_d = reg_wdata;
		end
		if (reg_rd) begin
			off = reg_addr - `IBG_ADDR_DATA_FIRST;
			if (reg_addr >= `IBG_ADDR_DATA_FIRST &&
				reg_addr <= `IBG_ADDR_DATA_LAST) begin
				// Even offset low byte, odd offset high byte
				rdata_d = off[0] ?
					channel_output_value[off[2:1]][15:8] :
					channel_output_value[off[2:1]][7:0];
			end else begin
				unique case (reg_addr)
					`IBG_ADDR_TRACK3: rdata_d = track3_q;
					`IBG_ADDR_MAKER_LO: rdata_d = MAKER_IDENTITY[7:0];
					`IBG_ADDR_MAKER_HI: rdata_d = MAKER_IDENTITY[15:8];
					`IBG_ADDR_PART_LO: rdata_d = part_lo;
					`IBG_ADDR_PART_HI: rdata_d = PART_IDENTITY_HI;
					default: rdata_d = `IBG_UNMAPPED_DATA;
				endcase
			end
		end
	end

	// Registers only
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			track3_q <= `IBG_TRACK3_RST;
			rdata_q <= `IBG_RDATA_RST;
			rvalid_q <= 1'b0;
			gain_q <= '{default: `IBG_GAIN_RST};
		end else begin
			track3_q <= track3_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			gain_q <= gain_d;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;
	assign channel_gain_factor = gain_q;
	assign ch3_fast_tracking_factor =
		track3_q[`IBG_TRACK3_MSB:`IBG_TRACK3_LSB];

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	ftf_reset_a: assert property (@(posedge sys_clk)
		$past(rst) && !rst |-> ch3_fast_tracking_factor == 2'h1)
		else $error("tracking factor not 1 after reset");

	ftf_write_a: assert property (@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == `IBG_ADDR_TRACK3 |=>
		ch3_fast_tracking_factor == $past(reg_wdata[1:0]))
		else $error("tracking register write lost");

	// Factor only moves on a write to its own register
	track_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		!(reg_wr && reg_addr == `IBG_ADDR_TRACK3) |=>
		$stable(ch3_fast_tracking_factor))
		else $error("tracking factor changed without write");

	maker_read_a: assert property (@(posedge sys_clk) disable iff (rst)
		reg_rd && reg_addr == `IBG_ADDR_MAKER_HI |=>
		reg_rvalid && reg_rdata == MAKER_IDENTITY[15:8])
		else $error("maker identity high byte wrong");

	part_read_a: assert property (@(posedge sys_clk) disable iff (rst)
		reg_rd && reg_addr == `IBG_ADDR_PART_LO |=>
		reg_rvalid && reg_rdata ==
		(FOUR_CHANNEL ? PART_LO_FOUR_CH : PART_LO_TWO_CH))
		else $error("part identity low byte wrong");

	gain_end_a: assert property (@(posedge sys_clk) disable iff (rst)
		channel_gain_code[3] == 6'h3F |=>
		channel_gain_factor[3] == `IBG_GAIN_MAX)
		else $error("gain code 63 not 232");

	gain_pow_a: assert property (@(posedge sys_clk) disable iff (rst)
		channel_gain_code[0][2:0] == 3'h0 |=>
		channel_gain_factor[0] == ibg_gain_type'(12'h010 <<
		$past(channel_gain_code[0][5:3])))
		else $error("gain power of two wrong");

	data_read_a: assert property (@(posedge sys_clk) disable iff (rst)
		reg_rd && reg_addr == `IBG_ADDR_DATA_LAST |=>
		reg_rvalid && reg_rdata == $past(channel_output_value[3][15:8]))
		else $error("last output byte wrong");

	unmapped_a: assert property (@(posedge sys_clk) disable iff (rst)
		reg_rd && reg_addr > `IBG_ADDR_DATA_LAST &&
		reg_addr < `IBG_ADDR_TRACK3 |=>
		reg_rvalid && reg_rdata == `IBG_UNMAPPED_DATA)
		else $error("unmapped read not zero");

	// ------------------------------------------------------------
	// Read port handshake
	// ------------------------------------------------------------
	rd_valid_a: assert property (@(posedge sys_clk) disable iff (rst)
		reg_rd |=> reg_rvalid)
		else $error("read not answered");

	// Valid follows the read strobe one cycle later, never raised without a read
	rd_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
		!reg_rd |=> !reg_rvalid)
		else $error("valid without read");

	// Read data stands until the next read
	rdata_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");

	// Port is idle while held in reset
	port_reset_a: assert property (@(posedge sys_clk)
		rst |=> reg_rdata == `IBG_RDATA_RST && !reg_rvalid)
		else $error("read port not idle after reset");

	// ------------------------------------------------------------
	// Identity and data bytes
	// ------------------------------------------------------------
	maker_low_a: assert property (@(posedge sys_clk) disable iff (rst)
		reg_rd && reg_addr == `IBG_ADDR_MAKER_LO |=>
		reg_rvalid && reg_rdata == MAKER_IDENTITY[7:0])
		else $error("maker identity low byte wrong");

	part_high_a: assert property (@(posedge sys_clk) disable iff (rst)
		reg_rd && reg_addr == `IBG_ADDR_PART_HI |=>
		reg_rvalid && reg_rdata == PART_IDENTITY_HI)
		else $error("part identity high byte wrong");

	data_first_a: assert property (@(posedge sys_clk) disable iff (rst)
		reg_rd && reg_addr == `IBG_ADDR_DATA_FIRST |=>
		reg_rvalid && reg_rdata == $past(channel_output_value[0][7:0]))
		else $error("first output byte wrong");

	// ------------------------------------------------------------
	// Gain factors
	// ------------------------------------------------------------
	gain_reset_a: assert property (@(posedge sys_clk)
		rst |=> channel_gain_factor[0] == `IBG_GAIN_RST)
		else $error("gain factor not 1.0 after reset");

	// Code 32 lands on a factor of 16
	gain_mid_a: assert property (@(posedge sys_clk) disable iff (rst)
		channel_gain_code[1] == 6'h20 |=>
		channel_gain_factor[1] == 12'h100)
		else $error("gain code 32 not 16");

	ftf_wr_cv: cover property (@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == `IBG_ADDR_TRACK3);
	gain_top_cv: cover property (@(posedge sys_clk) disable iff (rst)
		channel_gain_code[3] == 6'h3F);
	id_rd_cv: cover property (@(posedge sys_clk) disable iff (rst)
		reg_rd && reg_addr == `IBG_ADDR_PART_HI);
	data_rd_cv: cover property (@(posedge sys_clk) disable iff (rst)
		reg_rd && reg_addr == `IBG_ADDR_DATA_FIRST);
endmodule

// ---- verif/ibg_host.sv ----
// Host model driving the register port
`timescale 1ns/10ps
module ibg_host (
	// Clock
	input wire logic sys_clk,
	// Register port
	output ibg_pkg::ibg_addr_type reg_addr,
	output logic reg_wr,
	output ibg_pkg::ibg_byte_type reg_wdata,
	output logic reg_rd
);
	import ibg_pkg::*;
	// Idle port at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'h0;
		reg_wdata = 8'h00;
		reg_rd = 1'h0;
	end
	// One write strobe, then address and data scrambled
	task automatic wr(input ibg_addr_type a, input ibg_ftf_type v);
		@(posedge sys_clk) #5;
		reg_addr = a;
		reg_wdata = {6'h00, v};
		reg_wr = 1'h1;
		@(posedge sys_clk) #5;
		reg_wr = 1'h0;
		reg_addr = ~a;
		reg_wdata = ~reg_wdata;
	endtask
	// One read strobe
	task automatic rd(input ibg_addr_type a);
		@(posedge sys_clk) #5;
		reg_addr = a;
		reg_rd = 1'h1;
		@(posedge sys_clk) #5;
		reg_rd = 1'h0;
		reg_addr = ~a;
	endtask
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the register tail and gain decoder
`timescale 1ns/10ps
module tb;
	import ibg_pkg::*;
	localparam logic [15:0] MID = 16'hA5C3; // arbitrary value
	localparam logic [7:0] PHI = 8'h7D; // arbitrary value
	localparam logic [7:0] PLO = 8'h2E; // arbitrary value
	logic sys_clk;
	logic rst;
	ibg_addr_type reg_addr;
	logic reg_wr;
	logic reg_rd;
	logic reg_rvalid;
	ibg_byte_type reg_wdata;
	ibg_byte_type reg_rdata;
	ibg_data_arr_type chv;
	ibg_code_arr_type gc;
	ibg_gain_arr_type gf;
	ibg_ftf_type ftf;
	int bad_count = 0;
	int samples_checked = 0;
	integer seed = 32'h13EF;
	ibg_byte_type q[$];
	logic [11:0] mant [8] = '{12'h010, 12'h011, 12'h013, 12'h015,
		12'h017, 12'h019, 12'h01B, 12'h01D};
	ibg_regs #(.MAKER_IDENTITY(MID), .PART_IDENTITY_HI(PHI),
		.PART_LO_FOUR_CH(PLO)) uut (.sys_clk(sys_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.channel_output_value(chv), .channel_gain_code(gc),
		.channel_gain_factor(gf), .ch3_fast_tracking_factor(ftf));
	ibg_host host (.sys_clk(sys_clk), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
	// Clock
	initial begin
		sys_clk = 1'h0;
		forever #25 sys_clk = ~sys_clk;
	end
	// ------------------------------------------------------------
	// Checking
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic rd(input ibg_addr_type a, input ibg_byte_type e);
		q.push_back(e);
		host.rd(a);
	endtask
	task automatic results;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Read data compared against the oldest note
	always @(negedge sys_clk) begin
		if (reg_rvalid === 1'h1)
			chk(reg_rdata, q.size() ? q.pop_front() : 16'h100);
	end
	// Watchdog
	initial begin
		#100000;
		bad_count++;
		results;
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'h1;
		gc = '{default: 6'h00};
		for (int i = 0; i < 4; i++)
			chv[i] = 16'($random(seed));
		repeat (2) @(posedge sys_clk);
		#5 rst = 1'h0;
		chk(ftf, 16'h1);
		chk(gf[3], 16'h010);
		rd(8'h2B, 8'h01);
		for (int v = 3; v >= 0; v--) begin
			host.wr(8'h2B, 2'(v));
			@(posedge sys_clk) #5;
			chk(ftf, 16'(v));
			rd(8'h2B, 8'(v));
		end
		host.wr(8'hFC, 2'h3);
		rd(8'hFC, MID[7:0]);
		rd(8'hFD, MID[15:8]);
		rd(8'hFE, PLO);
		rd(8'hFF, PHI);
		for (int a = 0; a < 8; a++)
			rd(8'(a + 2), chv[a / 2][8 * (a % 2) +: 8]);
		rd(8'h10, 8'h00);
		for (int c = 0; c < 64; c++) begin
			gc[c % 4] = 6'(c);
			@(posedge sys_clk) #5;
			chk(gf[c % 4], mant[c % 8] << (c / 8));
		end
		repeat (2) @(posedge sys_clk);
		chk(16'(q.size()), 16'h0);
		results;
	end
endmodule
